/* pkg/ctc_defs.svh */
// Register offsets, field positions, reset values and widths of the timer block
`ifndef CTC_DEFS_SVH
`define CTC_DEFS_SVH
`define CTC_ADDR_W 8
`define CTC_OFF_MODE0 8'h00
`define CTC_OFF_MODE1 8'h04
`define CTC_OFF_MODE2 8'h08
`define CTC_OFF_LIM0 8'h0C
`define CTC_OFF_LIM1 8'h10
`define CTC_OFF_LIM2 8'h14
`define CTC_OFF_HLIM2 8'h18
`define CTC_OFF_CARR 8'h1C
`define CTC_OFF_CNT0 8'h20
`define CTC_OFF_CNT1 8'h24
`define CTC_OFF_CNT2 8'h28
`define CTC_OFF_STAT 8'h2C
`define CTC_OFF_MASK 8'h30
`define CTC_MODE_START_BIT 3
`define CTC_LIM_RST 8'hFF
`define CTC_MODE_RST 8'h00
`define CTC_CARR_RST 4'h0
`define CTC_PRESC_W 16
`define CTC_RESP_OKAY 2'h0
`define CTC_RESP_SLVERR 2'h2
`endif

/* pkg/ctc_pkg.sv */
// Types shared by the carrier timer counter modules
package ctc_pkg;
   typedef enum logic [1:0] {
      MODE_COUNT8 = 2'b00,
      MODE_RSV1 = 2'b01,
      MODE_RSV2 = 2'b10,
      MODE_CARRIER = 2'b11
   } op_mode_e;
   typedef enum logic {
      PH_HIGH = 1'b0,
      PH_LOW = 1'b1
   } phase_e;
   // Mode register layout: pulse select, start, count enable, mode
   typedef struct packed {
      logic [3:0] sel;
      logic start;
      logic en;
      op_mode_e mode;
   } mode_s;
   // Carrier control layout
   typedef struct packed {
      logic toggle_ro;
      logic level_only;
      logic gate;
      logic gate_buf;
   } carr_s;
   typedef struct packed {
      logic en;
      logic carrier;
      logic [7:0] lim_lo;
      logic [7:0] lim_hi;
   } chan_cfg_s;
   typedef struct packed {
      logic [7:0] cnt;
      phase_e phase;
      logic toggle_output_ff;
      logic match;
   } chan_st_s;
   typedef struct packed {
      logic [15:0] cnt;
   } presc_st_s;
endpackage

/* sim/carrier_timer_counter_assertions.sv */
// Bus handshake and reset checks on the timer block ports
`timescale 1ns/1ns
module carrier_timer_counter_assertions (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic carrier_output_pin,
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !ce);
   AST_WR_RESP: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write answer late");
   AST_B_HOLD: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   AST_AW_BLOCK: assert property (
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("address slot not closed");
   AST_RD_RESP: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_R_HOLD: assert property (
      s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer changed");
   AST_AR_BLOCK: assert property (
      s_axi_rvalid |-> !s_axi_arready) else $error("read slot open");
   AST_R_DONE: assert property (
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read answer not retired");
   AST_RST_QUIET: assert property (
      $rose(aresetn) |-> !carrier_output_pin && !irq && !s_axi_bvalid)
      else $error("outputs active after reset");
endmodule
bind carrier_timer_counter carrier_timer_counter_assertions chk_u (.*);

/* sim/ir_receiver_model.sv */
// Receiver model that counts carrier pulses seen on the output pin
`timescale 1ns/1ns
module ir_receiver_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin,
   output logic [15:0] rises
);
   logic pin_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_r <= 1'b0;
         rises <= 16'h0;
      end else begin
         pin_r <= pin;
         if (pin && !pin_r) rises <= rises + 16'h1;
      end
   end
endmodule

/* sim/tb_carrier_timer_counter.sv */
// Self-checking bench for the carrier timer counter
`timescale 1ns/1ns
`include "ctc_defs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
   $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_carrier_timer_counter;
   logic aclk = 0, aresetn = 0, ce = 1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, seed = 32'h5027357D;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, pin, irq;
   logic [1:0] bresp, rresp;
   logic [15:0] rises, r0;
   logic [1:0] bq[$];
   logic [33:0] rq[$];
   logic [33:0] r_exp;
   logic [1:0] b_exp;
   int errors = 0, checks_done = 0;
   always #2 aclk = ~aclk;
   carrier_timer_counter dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .carrier_output_pin(pin), .irq(irq));
   ir_receiver_model rx_u (.aclk(aclk), .aresetn(aresetn), .pin(pin),
      .rises(rises));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
      input logic [1:0] r = `CTC_RESP_OKAY);
      bq.push_back(r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      while (!bvalid) @(posedge aclk);
      bready <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] d,
      input logic [1:0] r = `CTC_RESP_OKAY);
      rq.push_back({r, 24'h0, d});
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      do @(posedge aclk); while (!rvalid);
      rready <= 0;
   endtask
   task automatic conclude;
      if (errors == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge aclk) begin
      if (rvalid && rready) begin
         r_exp = rq.pop_front();
         `CHK({rresp, rdata}, r_exp)
      end
      if (bvalid && bready) begin
         b_exp = bq.pop_front();
         `CHK(bresp, b_exp)
      end
   end
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1;
      rd(`CTC_OFF_MODE0, `CTC_MODE_RST);
      rd(`CTC_OFF_HLIM2, `CTC_LIM_RST);
      rd(`CTC_OFF_CARR, 8'h00);
      rd(8'h40, 8'h00, `CTC_RESP_SLVERR);
      wr(8'h40, 8'h55, `CTC_RESP_SLVERR);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         wr(`CTC_OFF_LIM0 + 8'(4 * i), seed[7:0]);
         rd(`CTC_OFF_LIM0 + 8'(4 * i), seed[7:0]);
      end
      wr(`CTC_OFF_LIM1, 8'h03);
      wr(`CTC_OFF_MODE1, 8'h6C);
      repeat (400) @(posedge aclk);
      `CHK(irq, 1'b0)
      rd(`CTC_OFF_STAT, 8'h02);
      wr(`CTC_OFF_MODE1, 8'h6C);
      wr(`CTC_OFF_MODE1, 8'h6C);
      rd(`CTC_OFF_STAT, 8'h00);
      wr(`CTC_OFF_MASK, 8'h02);
      repeat (400) @(posedge aclk);
      `CHK(irq, 1'b1)
      wr(`CTC_OFF_MODE1, 8'h00);
      wr(`CTC_OFF_STAT, 8'h07);
      repeat (3) @(posedge aclk);
      `CHK(irq, 1'b0)
      wr(`CTC_OFF_LIM0, 8'hC8);
      wr(`CTC_OFF_MODE0, 8'h4C);
      repeat (1600) @(posedge aclk);
      wr(`CTC_OFF_LIM0, 8'h0A);
      repeat (800) @(posedge aclk);
      rd(`CTC_OFF_STAT, 8'h00);
      repeat (2200) @(posedge aclk);
      rd(`CTC_OFF_STAT, 8'h01);
      wr(`CTC_OFF_MODE0, 8'h4C);
      wr(`CTC_OFF_MODE0, 8'h4C);
      ce <= 1'b0;
      repeat (200) @(posedge aclk);
      ce <= 1'b1;
      repeat (140) @(posedge aclk);
      rd(`CTC_OFF_STAT, 8'h00);
      repeat (40) @(posedge aclk);
      rd(`CTC_OFF_STAT, 8'h01);
      wr(`CTC_OFF_MODE0, 8'h00);
      wr(`CTC_OFF_HLIM2, 8'h03);
      wr(`CTC_OFF_LIM2, 8'h03);
      wr(`CTC_OFF_CARR, 8'h00);
      wr(`CTC_OFF_MODE2, 8'h0F);
      r0 = rises;
      repeat (200) @(posedge aclk);
      `CHK(rises, r0)
      wr(`CTC_OFF_CARR, 8'h02);
      r0 = rises;
      repeat (200) @(posedge aclk);
      `CHK((rises - r0) inside {[24:26]}, 1'b1)
      wr(`CTC_OFF_CARR, 8'h01);
      repeat (20) @(posedge aclk);
      r0 = rises;
      repeat (100) @(posedge aclk);
      `CHK(rises, r0)
      wr(`CTC_OFF_LIM1, 8'h0F);
      wr(`CTC_OFF_MODE1, 8'h0C);
      repeat (100) @(posedge aclk);
      r0 = rises;
      repeat (100) @(posedge aclk);
      `CHK((rises - r0) inside {[11:13]}, 1'b1)
      wr(`CTC_OFF_CARR, 8'h00);
      repeat (20) @(posedge aclk);
      r0 = rises;
      repeat (100) @(posedge aclk);
      `CHK(rises, r0)
      conclude();
   end
   initial begin
      #80000;
      errors++;
      conclude();
   end
endmodule

/* src/carrier_timer_counter.sv */
// Three timer counters with carrier generator behind an AXI4-Lite slave
// Operation
// RULE1 - Start bit clears count and match flag
// RULE2 - Start clear is not aligned to count pulse
// RULE3 - Fast pulse may add two pulses error
// RULE4 - Match at start may leave flag set
// RULE5 - Software stops then restarts, or starts twice
// RULE6 - New pulse selection acts at once
// RULE7 - Software starts when changing pulse selection
// RULE8 - Limit writes take effect immediately
// RULE9 - Limit below count: count wraps through overflow
// RULE10 - Software restarts after lowering a limit
// RULE11 - Software sets gate after starting channel two
// RULE12 - Gate reload waits for carrier low
// RULE13 - Forced gate and restart may lengthen high
// RULE14 - Zero write enables carrier, clears gate flags
// RULE15 - Mode pattern selects pulse, counter, enable, start
// RULE16 - Gate buffer loads gate at channel one match
// RULE17 - Pin shows carrier or high when gated, else low
// RULE18 - Carrier toggles on high and low limits
// RULE19 - Match clears count on next pulse
`timescale 1ns/1ns
`include "ctc_defs.svh"
module carrier_timer_counter (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic carrier_output_pin,
   output logic irq
);
   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_full;
      logic w_full;
      logic [7:0] aw_addr;
      logic [7:0] w_data;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      ctc_pkg::mode_s [2:0] timer_mode_reg;
      logic [2:0][7:0] period_limit_reg;
      logic [7:0] high_period_limit_reg;
      logic gate_buf;
      logic gate;
      logic level_only;
      logic out_gate;
      logic [2:0] start;
      logic [2:0] timer_match_flag;
      logic [2:0] irq_mask;
      logic pin;
      logic irq;
   } top_st_s;

   top_st_s st_r;
   top_st_s st_nxt;
   logic [2:0] count_pulse;
   ctc_pkg::chan_cfg_s [2:0] cfg;
   ctc_pkg::chan_st_s [2:0] ch;
   logic do_write;
   logic [7:0] wd;
   logic [31:0] rd;
   logic rd_ok;
   logic [2:0] match_evt;

   assign s_axi_awready = st_r.awready;
   assign s_axi_wready = st_r.wready;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = st_r.arready;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rresp = st_r.rresp;
   assign s_axi_rdata = st_r.rdata;
   assign carrier_output_pin = st_r.pin;
   assign irq = st_r.irq;

   // One shared prescaler serves all three channels
   count_pulse_gen #(
      .W(`CTC_PRESC_W)
   ) u_presc (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .sel0(st_r.timer_mode_reg[0].sel),
      .sel1(st_r.timer_mode_reg[1].sel),
      .sel2(st_r.timer_mode_reg[2].sel),
      .count_pulse(count_pulse)
   );

   // Limits feed compare directly, so writes act at once
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         cfg[i].en = st_r.timer_mode_reg[i].en;
         cfg[i].carrier = (i == 2) &&
            (st_r.timer_mode_reg[i].mode == ctc_pkg::MODE_CARRIER);
         cfg[i].lim_lo = st_r.period_limit_reg[i]; // RULE8
         cfg[i].lim_hi = st_r.high_period_limit_reg; // RULE8
      end
   end

   // Only channel two may run in carrier mode
   timer_channel u_chan0 (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .tick(count_pulse[0]),
      .start(st_r.start[0]),
      .cfg(cfg[0]),
      .st(ch[0])
   );

   timer_channel u_chan1 (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .tick(count_pulse[1]),
      .start(st_r.start[1]),
      .cfg(cfg[1]),
      .st(ch[1])
   );

   timer_channel u_chan2 (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .tick(count_pulse[2]),
      .start(st_r.start[2]),
      .cfg(cfg[2]),
      .st(ch[2])
   );

   assign match_evt = {ch[2].match, ch[1].match, ch[0].match};

   // Start is a strobe, so it always reads back as zero
   function automatic logic [7:0] mode_view(input ctc_pkg::mode_s m);
      mode_view = {m.sel, 1'b0, m.en, m.mode};
   endfunction

   // Start is never held in the register, only passed on
   function automatic ctc_pkg::mode_s mode_store(input logic [7:0] d);
      mode_store = d;
      mode_store.start = 1'b0;
   endfunction

   // Read decode
   always_comb begin
      rd = 32'h00000000;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `CTC_OFF_MODE0: begin
            rd[7:0] = mode_view(st_r.timer_mode_reg[0]);
         end
         `CTC_OFF_MODE1: begin
            rd[7:0] = mode_view(st_r.timer_mode_reg[1]);
         end
         `CTC_OFF_MODE2: begin
            rd[7:0] = mode_view(st_r.timer_mode_reg[2]);
         end
         `CTC_OFF_LIM0: begin
            rd[7:0] = st_r.period_limit_reg[0];
         end
         `CTC_OFF_LIM1: begin
            rd[7:0] = st_r.period_limit_reg[1];
         end
         `CTC_OFF_LIM2: begin
            rd[7:0] = st_r.period_limit_reg[2];
         end
         `CTC_OFF_HLIM2: begin
            rd[7:0] = st_r.high_period_limit_reg;
         end
         `CTC_OFF_CARR: begin
            // Toggle state readable, never writable
            rd[3:0] = {ch[2].toggle_output_ff, st_r.level_only, st_r.gate,
               st_r.gate_buf};
         end
         `CTC_OFF_CNT0: begin
            rd[7:0] = ch[0].cnt;
         end
         `CTC_OFF_CNT1: begin
            rd[7:0] = ch[1].cnt;
         end
         `CTC_OFF_CNT2: begin
            rd[7:0] = ch[2].cnt;
         end
         `CTC_OFF_STAT: begin
            rd[2:0] = st_r.timer_match_flag;
         end
         `CTC_OFF_MASK: begin
            rd[2:0] = st_r.irq_mask;
         end
         default: begin
            rd_ok = 1'b0;
         end
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.start = 3'b000;
      do_write = 1'b0;
      wd = st_r.w_data;

      // Write address and data are taken in either order
      if (s_axi_awvalid && st_r.awready) begin
         st_nxt.aw_full = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_r.wready) begin
         st_nxt.w_full = 1'b1;
         st_nxt.w_data = s_axi_wdata[7:0];
         st_nxt.w_lane0 = s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      // Register effects land with the raised response
      if (st_r.aw_full && st_r.w_full && !st_r.bvalid) begin
         do_write = st_r.w_lane0;
         st_nxt.aw_full = 1'b0;
         st_nxt.w_full = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = `CTC_RESP_OKAY;
      end

      // Start strobes clear match flags
      for (int i = 0; i < 3; i++) begin
         if (st_r.start[i]) begin
            st_nxt.timer_match_flag[i] = 1'b0; // RULE1
         end
      end

      // Gate buffer moves into gate at channel one match
      if (match_evt[1]) begin
         st_nxt.gate = st_r.gate_buf; // RULE16
      end

      if (do_write) begin
         case (st_r.aw_addr)
            `CTC_OFF_MODE0: begin
               // Whole pattern lands in one write
               st_nxt.timer_mode_reg[0] = mode_store(wd); // RULE15 RULE6
               st_nxt.start[0] = wd[`CTC_MODE_START_BIT]; // RULE1
            end
            `CTC_OFF_MODE1: begin
               st_nxt.timer_mode_reg[1] = mode_store(wd); // RULE15 RULE6
               st_nxt.start[1] = wd[`CTC_MODE_START_BIT]; // RULE1
            end
            `CTC_OFF_MODE2: begin
               st_nxt.timer_mode_reg[2] = mode_store(wd); // RULE15 RULE6
               st_nxt.start[2] = wd[`CTC_MODE_START_BIT]; // RULE1
            end
            `CTC_OFF_LIM0: begin
               st_nxt.period_limit_reg[0] = wd; // RULE8
            end
            `CTC_OFF_LIM1: begin
               st_nxt.period_limit_reg[1] = wd; // RULE8
            end
            `CTC_OFF_LIM2: begin
               st_nxt.period_limit_reg[2] = wd; // RULE8
            end
            `CTC_OFF_HLIM2: begin
               st_nxt.high_period_limit_reg = wd; // RULE8
            end
            `CTC_OFF_CARR: begin
               // Zero write: carrier on, both gate flags cleared
               st_nxt.gate_buf = wd[0]; // RULE14
               st_nxt.gate = wd[1]; // RULE14 RULE13
               st_nxt.level_only = wd[2]; // RULE14
            end
            `CTC_OFF_STAT: begin
               st_nxt.timer_match_flag = st_nxt.timer_match_flag &
                  ~wd[2:0];
            end
            `CTC_OFF_MASK: begin
               st_nxt.irq_mask = wd[2:0];
            end
            default: begin
               st_nxt.bresp = `CTC_RESP_SLVERR;
            end
         endcase
      end

      // Set wins over start clear and software clear
      st_nxt.timer_match_flag = st_nxt.timer_match_flag |
         match_evt; // RULE4

      // Gate reaches the pin only while the carrier is low or level_only is set,
      // so a high pulse is never cut short
      if (st_r.level_only || !ch[2].toggle_output_ff) begin
         st_nxt.out_gate = st_nxt.gate; // RULE12
      end
      st_nxt.pin = st_r.out_gate &
         (st_r.level_only | ch[2].toggle_output_ff); // RULE17

      // Read channel
      if (s_axi_rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_r.arready) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata = rd;
         st_nxt.rresp = rd_ok ? `CTC_RESP_OKAY : `CTC_RESP_SLVERR;
      end
      // One read at a time; no new address while data waits
      st_nxt.arready = !st_nxt.rvalid &&
         !(s_axi_arvalid && st_r.arready);
      st_nxt.awready = !st_nxt.aw_full;
      st_nxt.wready = !st_nxt.w_full;

      // Level interrupt from unmasked sticky flags
      st_nxt.irq = |(st_nxt.timer_match_flag & st_nxt.irq_mask);
   end

   // Limits come out of reset at all ones, the rest at zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
         st_r.period_limit_reg <= {3{`CTC_LIM_RST}};
         st_r.high_period_limit_reg <= `CTC_LIM_RST;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end
endmodule

/* src/count_pulse_gen.sv */
// Free-running prescaler that derives three selectable count pulses
`timescale 1ns/1ns
module count_pulse_gen #(
   parameter int W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [3:0] sel0,
   input wire logic [3:0] sel1,
   input wire logic [3:0] sel2,
   output logic [2:0] count_pulse
);
   ctc_pkg::presc_st_s st_r;
   ctc_pkg::presc_st_s st_nxt;

   // Selection 0 pulses every clock, faster than a machine cycle
   function automatic logic pulse_of(input logic [15:0] c,
                                     input logic [3:0] s);
      logic [16:0] m;
      m = (17'h00001 << s) - 17'h00001;
      pulse_of = ((c & m[15:0]) == m[15:0]);
   endfunction

   // Selection acts at once, without waiting for the old pulse
   always_comb begin
      count_pulse[0] = pulse_of(st_r.cnt, sel0); // RULE6 RULE3
      count_pulse[1] = pulse_of(st_r.cnt, sel1); // RULE6
      count_pulse[2] = pulse_of(st_r.cnt, sel2); // RULE6
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.cnt = st_r.cnt + 16'h0001;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end
endmodule

/* src/timer_channel.sv */
// One 8-bit modulo counter with optional carrier toggle output
`timescale 1ns/1ns
module timer_channel (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic tick,
   input wire logic start,
   input ctc_pkg::chan_cfg_s cfg,
   output ctc_pkg::chan_st_s st
);
   ctc_pkg::chan_st_s st_r;
   ctc_pkg::chan_st_s st_nxt;
   logic [7:0] cmp;

   assign st = st_r;

   always_comb begin
      st_nxt = st_r;
      st_nxt.match = 1'b0;
      cmp = (cfg.carrier && st_r.phase == ctc_pkg::PH_HIGH) ?
            cfg.lim_hi : cfg.lim_lo;
      if (start) begin
         // Clear on the CPU clock, not aligned to the count pulse
         st_nxt.cnt = 8'h00; // RULE1 RULE2
         // Toggle kept, so a high level may be lengthened
         st_nxt.phase = ctc_pkg::PH_HIGH; // RULE13
      end else if (cfg.en && tick) begin
         if (st_r.cnt == cmp) begin
            st_nxt.cnt = 8'h00; // RULE19
            if (cfg.carrier) begin
               st_nxt.toggle_output_ff = ~st_r.toggle_output_ff; // RULE18
               if (st_r.phase == ctc_pkg::PH_HIGH) begin
                  st_nxt.phase = ctc_pkg::PH_LOW; // RULE18
               end else begin
                  st_nxt.phase = ctc_pkg::PH_HIGH; // RULE18
                  st_nxt.match = 1'b1; // RULE18
               end
            end else begin
               st_nxt.match = 1'b1;
            end
         end else begin
            // Limit below count: run on through 8'hFF and wrap
            st_nxt.cnt = st_r.cnt + 8'h01; // RULE9
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end
endmodule
